//--- core/fcmc_pkg.sv
package fcmc_pkg;

    // ------------------------------------------------------------------
    // Register indices (word address = index, byte address = 4 x index).
    // ------------------------------------------------------------------
    localparam logic [11:0] REG_STAGING_IDX   = 12'hFD0;
    localparam logic [11:0] REG_COMMIT_IDX    = 12'hFD1; // Read: monitor.
    localparam logic [11:0] REG_STANDBY_IDX   = 12'hFD2;
    localparam logic [11:0] REG_PROM_PORT_IDX = 12'hFD3;
    localparam logic [11:0] REG_SYS_CFG3_IDX  = 12'hFD4;
    localparam logic [11:0] REG_SYS_COMMIT_IDX = 12'hFD5;

    // ------------------------------------------------------------------
    // Keys, field values, field positions and reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0] FLASH_KEY     = 8'hD5;
    localparam logic [7:0] SYS_KEY       = 8'hD4;
    localparam logic [2:0] MODE_ENABLE   = 3'h5;
    localparam logic [2:0] MODE_DISABLE  = 3'h2;
    localparam logic [1:0] AREA_STD      = 2'h0;
    localparam logic [1:0] AREA_CODE     = 2'h2;
    localparam int         STG_MODE_LSB  = 5;
    localparam int         STG_BOOT_BIT  = 4;
    localparam int         STG_AREA_LSB  = 2;
    localparam int         ACT_MODE_LSB  = 3;
    localparam int         ACT_BOOT_BIT  = 2;
    localparam int         MON_MODE_BIT  = 5;
    localparam int         SYS_RAM_REMAP_BIT_BIT = 0;
    localparam int         SYS_VECTOR_IN_RAM_BIT_BIT = 1;
    localparam int         PP_OTHER_BIT  = 0;
    localparam int         PP_SCLK_BIT   = 1;
    localparam int         STBY_BIT      = 0;
    localparam int         TOGGLE_BIT    = 6;
    localparam logic [7:0] STAGING_RST   = 8'h40;
    localparam logic [5:0] FLASH_ACT_RST = 6'h10;
    localparam logic [1:0] SYS_ACT_RST   = 2'h0;

    // ------------------------------------------------------------------
    // Command sequence codes and address windows.
    // ------------------------------------------------------------------
    localparam logic [11:0] CMD_ADDR_A   = 12'h555;
    localparam logic [11:0] CMD_ADDR_B   = 12'hAAA;
    localparam logic [7:0]  CMD_UNLOCK1  = 8'hAA;
    localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;
    localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
    localparam logic [7:0]  CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0]  CMD_ID_EXIT  = 8'hF0;
    localparam logic [7:0]  CMD_ERASE    = 8'h80;
    localparam logic [7:0]  CMD_SECTOR   = 8'h30;
    localparam logic [7:0]  CMD_CHIP     = 8'h10;
    localparam logic [15:0] FLASH_LO     = 16'h8000;
    localparam logic [15:0] BOOT_LO      = 16'h1000;
    localparam logic [15:0] BOOT_DATA_HI = 16'h17FF;
    localparam logic [15:0] BOOT_PROM_HI = 16'h1FFF;

    typedef enum logic [2:0] {
        CMD_IDLE, CMD_UNL1, CMD_UNL2, CMD_PROG, CMD_ERA1, CMD_ERA2, CMD_ERA3
    } fcmc_cmd_state_t;

endpackage

//--- core/fcmc_cmd_if.sv
`timescale 1ns/1ns
interface fcmc_cmd_if;
    logic        wr;
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        prog;
    logic        sec_erase;
    logic        chip_erase;
    logic        id_mode;
    logic [15:0] tgt_addr;
    logic [7:0]  tgt_data;

    modport dec (input wr, en, addr, data,
                 output prog, sec_erase, chip_erase, id_mode,
                 tgt_addr, tgt_data);
    modport ctl (output wr, en, addr, data,
                 input prog, sec_erase, chip_erase, id_mode,
                 tgt_addr, tgt_data);
endinterface

//--- core/fcmc_commit_reg.sv
`timescale 1ns/1ns
module fcmc_commit_reg #(
    parameter int             W   = 6,
    parameter logic [W-1:0]   RST = '0,
    parameter logic [7:0]     KEY = 8'h00
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         commit_wr,
    input  wire logic [7:0]   commit_data,
    input  wire logic [W-1:0] staged,
    output logic      [W-1:0] active
);
    typedef struct packed {
        logic [W-1:0] act;
    } fcmc_commit_state_t;

    fcmc_commit_state_t st_r;
    fcmc_commit_state_t st_nxt;

    // The staged copy reaches the active copy only on the exact key.
    always_comb begin
        st_nxt = st_r;
        if (commit_wr && (commit_data == KEY)) begin
            st_nxt.act = staged;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r <= RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign active = st_r.act;
endmodule

//--- core/fcmc_cmd_decoder.sv
`timescale 1ns/1ns
module fcmc_cmd_decoder (
    input wire logic clk_sys,
    input wire logic sys_rst,
    fcmc_cmd_if.dec  cmd
);
    import fcmc_pkg::*;

    typedef struct packed {
        fcmc_cmd_state_t st;
        logic            id_mode;
        logic            prog;
        logic            sec_erase;
        logic            chip_erase;
        logic [15:0]     tgt_addr;
        logic [7:0]      tgt_data;
    } fcmc_dec_state_t;

    fcmc_dec_state_t s_r;
    fcmc_dec_state_t s_nxt;
    logic            in_flash;
    logic            is_a;
    logic            is_b;

    // The upper nibble may be 8 to F, so only the top address bit counts.
    assign in_flash = cmd.addr[15];
    assign is_a     = in_flash && (cmd.addr[11:0] == CMD_ADDR_A);
    assign is_b     = in_flash && (cmd.addr[11:0] == CMD_ADDR_B);

    // Writes while disabled leave the state alone, so a sequence already
    // under way is neither advanced nor reset by them.
    always_comb begin
        s_nxt            = s_r;
        s_nxt.prog       = 1'b0;
        s_nxt.sec_erase  = 1'b0;
        s_nxt.chip_erase = 1'b0;
        if (cmd.wr && cmd.en) begin // [RL3] [RL5]
            s_nxt.st = CMD_IDLE; // [RL26]
            if (cmd.data == CMD_ID_EXIT) begin
                s_nxt.id_mode = 1'b0; // [RL21]
            end
            case (s_r.st)
                CMD_IDLE: begin
                    if (is_a && cmd.data == CMD_UNLOCK1) s_nxt.st = CMD_UNL1;
                end
                CMD_UNL1: begin
                    if (is_b && cmd.data == CMD_UNLOCK2) s_nxt.st = CMD_UNL2;
                end
                CMD_UNL2: begin
                    if (is_a && cmd.data == CMD_PROGRAM) begin
                        s_nxt.st = CMD_PROG; // [RL21]
                    end else if (is_a && cmd.data == CMD_ID_ENTRY) begin
                        s_nxt.id_mode = 1'b1; // [RL21]
                    end else if (is_a && cmd.data == CMD_ERASE) begin
                        s_nxt.st = CMD_ERA1; // [RL22]
                    end
                end
                CMD_PROG: begin
                    if (in_flash) begin
                        s_nxt.prog     = 1'b1; // [RL21]
                        s_nxt.tgt_addr = cmd.addr;
                        s_nxt.tgt_data = cmd.data;
                    end
                end
                CMD_ERA1: begin
                    if (is_a && cmd.data == CMD_UNLOCK1) s_nxt.st = CMD_ERA2;
                end
                CMD_ERA2: begin
                    if (is_b && cmd.data == CMD_UNLOCK2) s_nxt.st = CMD_ERA3;
                end
                CMD_ERA3: begin
                    if (in_flash && cmd.data == CMD_SECTOR) begin
                        s_nxt.sec_erase = 1'b1; // [RL22]
                        s_nxt.tgt_addr  = cmd.addr;
                    end else if (is_a && cmd.data == CMD_CHIP) begin
                        s_nxt.chip_erase = 1'b1; // [RL22]
                    end
                end
                default: s_nxt.st = CMD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_r <= '{st: CMD_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cmd.prog       = s_r.prog;
    assign cmd.sec_erase  = s_r.sec_erase;
    assign cmd.chip_erase = s_r.chip_erase;
    assign cmd.id_mode    = s_r.id_mode;
    assign cmd.tgt_addr   = s_r.tgt_addr;
    assign cmd.tgt_data   = s_r.tgt_data;
endmodule

//--- core/fcmc_top.sv
//Function
// (RL1) 101 then key D5 enables commands
// (RL2) 010 then key D5 write-protects flash
// (RL3) Disabled: commands and toggle reads ignored
// (RL4) Reset leaves command mode at 010
// (RL5) Disabling does not reset running sequence
// (RL6) Area 10 maps code window onto data
// (RL7) Area 00 restores default data mapping
// (RL8) Commands only through data window transfers
// (RL9) Both windows reach same physical cells
// (RL10) RAM remap bit committed by key D4
// (RL11) Serial PROM mode always maps RAM
// (RL12) Boot show bit maps boot ROM
// (RL13) PROM mode: boot ROM fixed, reads 1
// (RL14) Standby writes accepted only from RAM
// (RL15) Flash access in standby causes reset
// (RL16) Vector in flash: clear standby first
// (RL17) Vector in RAM: standby stays set
// (RL18) PROM mode: port inputs off after reset
// (RL19) Enable bits open serial clock, ports
// (RL20) MCU mode: port control has no effect
// (RL21) Unlock AA/55 then program or ID
// (RL22) Erase: 80, unlock, then 30 or 10
// (RL23) Command address nibble from 8 to F
// (RL24) Busy reads toggle bit six
// (RL25) Staging copied to active on key
// (RL26) Mismatched write returns decoder to idle
`timescale 1ns/1ns
module fcmc_top (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        prom_mode,
    input  wire logic        sw_exec_from_ram,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_code_space,
    input  wire logic        cpu_fetch,
    input  wire logic        cpu_rd,
    input  wire logic        cpu_wr,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        irq_vector_start,
    input  wire logic [7:0]  flash_rdata,
    input  wire logic        flash_busy,
    output logic      [7:0]  cpu_rdata,
    output logic             flash_sel,
    output logic             bootrom_sel,
    output logic             ram_in_code,
    output logic             code_window_mapped,
    output logic             vector_from_ram,
    output logic      [15:0] flash_tgt_addr,
    output logic      [7:0]  flash_tgt_data,
    output logic             flash_program,
    output logic             flash_sector_erase,
    output logic             flash_chip_erase,
    output logic             flash_id_mode,
    output logic             cmd_enabled,
    output logic             standby_reset,
    output logic             sclk_in_en,
    output logic             other_in_en
);
    import fcmc_pkg::*;

    // ------------------------------------------------------------------
    // State and wiring.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  stage;
        logic        stby;
        logic [1:0]  pport;
        logic [1:0]  sys;
        logic        ack;
        logic [31:0] rdata;
        logic        tog;
        logic [7:0]  crd;
        logic        srst;
    } fcmc_top_state_t;

    fcmc_top_state_t s_r;
    fcmc_top_state_t s_nxt;
    logic [5:0]      flash_act;
    logic [1:0]      sys_act;
    logic [1:0]      area_act;
    logic            boot_shown;
    logic            wr_go;
    logic            rd_go;
    logic [7:0]      wbyte;
    logic            in_boot_data;
    logic            in_boot_code;
    logic            flash_acc;
    logic            rd_toggle;
    logic [7:0]      monitor;
    fcmc_cmd_if      cmd ();

    // ------------------------------------------------------------------
    // Commit units: staged bits reach the logic only on the key write.
    // ------------------------------------------------------------------
    fcmc_commit_reg #(.W(6), .RST(FLASH_ACT_RST), .KEY(FLASH_KEY)) u_flash (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .commit_wr   (wr_go && avs_address == REG_COMMIT_IDX), // [RL25]
        .commit_data (wbyte),
        .staged      (s_r.stage[7:2]),
        .active      (flash_act)
    );

    fcmc_commit_reg #(.W(2), .RST(SYS_ACT_RST), .KEY(SYS_KEY)) u_sys (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .commit_wr   (wr_go && avs_address == REG_SYS_COMMIT_IDX), // [RL10]
        .commit_data (wbyte),
        .staged      (s_r.sys),
        .active      (sys_act)
    );

    fcmc_cmd_decoder u_dec (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .cmd     (cmd)
    );

    // ------------------------------------------------------------------
    // Mapping and decode.
    // ------------------------------------------------------------------
    // Only the exact enable pattern opens the sequencer; any other
    // committed value, reserved ones included, keeps it protected.
    assign cmd_enabled = (flash_act[5:3] == MODE_ENABLE); // [RL1] [RL2]
    assign area_act    = flash_act[1:0];
    // In serial PROM mode the show bit is forced regardless of writes.
    assign boot_shown  = prom_mode || flash_act[ACT_BOOT_BIT]; // [RL12]
    assign code_window_mapped = (area_act == AREA_CODE); // [RL6] [RL7]
    assign ram_in_code = prom_mode || sys_act[SYS_RAM_REMAP_BIT_BIT]; // [RL10] [RL11]
    assign vector_from_ram = sys_act[SYS_VECTOR_IN_RAM_BIT_BIT];

    assign in_boot_data = (cpu_addr >= BOOT_LO) && (cpu_addr <= BOOT_DATA_HI);
    assign in_boot_code = prom_mode && cpu_code_space
                       && (cpu_addr >= BOOT_LO) && (cpu_addr <= BOOT_PROM_HI);
    assign bootrom_sel  = (in_boot_data && boot_shown) || in_boot_code; // [RL13]
    // Both views drive the same low address bits, hence the same cell.
    assign flash_sel    = (cpu_addr >= FLASH_LO)
                       || (in_boot_data && !bootrom_sel); // [RL9]
    assign flash_acc    = flash_sel && (cpu_rd || cpu_wr || cpu_fetch);
    assign rd_toggle    = cpu_rd && flash_sel && flash_busy && cmd_enabled;

    // Commands are only seen as data-space transfers of the CPU.
    assign cmd.wr   = cpu_wr && !cpu_code_space; // [RL8]
    assign cmd.en   = cmd_enabled; // [RL3]
    assign cmd.addr = cpu_addr;
    assign cmd.data = cpu_wdata;

    // Port gating only bites in serial PROM mode; both input groups are gated there.
    assign sclk_in_en  = !prom_mode || s_r.pport[PP_SCLK_BIT]; // [RL19] [RL20]
    assign other_in_en = !prom_mode || s_r.pport[PP_OTHER_BIT]; // [RL18]

    // ------------------------------------------------------------------
    // Register bus: one wait state, effect at the edge of release.
    // ------------------------------------------------------------------
    assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
    assign wr_go = avs_write && s_r.ack;
    assign rd_go = avs_read && !s_r.ack;
    assign wbyte = avs_writedata[7:0];

    assign monitor = {2'b00, cmd_enabled, boot_shown, area_act, 2'b00};

    // Next state of registers, bus answer, standby and toggle logic.
    always_comb begin
        s_nxt      = s_r;
        s_nxt.ack  = (avs_read || avs_write) && !s_r.ack;
        s_nxt.srst = s_r.stby && flash_acc; // [RL15] [RL17]
        if (rd_go) begin
            s_nxt.rdata = 32'h0000_0000;
            case (avs_address)
                REG_STAGING_IDX: begin
                    // The staged show bit reads back, forced to 1 in PROM.
                    s_nxt.rdata[7:0] = s_r.stage;
                    s_nxt.rdata[STG_BOOT_BIT] = prom_mode
                                             || s_r.stage[STG_BOOT_BIT];
                end
                REG_COMMIT_IDX:    s_nxt.rdata[7:0] = monitor; // [RL25]
                REG_PROM_PORT_IDX: s_nxt.rdata[1:0] = prom_mode ? s_r.pport
                                                                : 2'b00;
                REG_SYS_CFG3_IDX:  s_nxt.rdata[1:0] = s_r.sys;
                default:           s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // The hardware clear comes first so that a software set in the
        // same cycle still wins.
        if (irq_vector_start && !vector_from_ram) begin
            s_nxt.stby = 1'b0; // [RL16]
        end
        if (wr_go) begin
            case (avs_address)
                REG_STAGING_IDX: begin
                    s_nxt.stage = {wbyte[7:2], 2'b00};
                    if (prom_mode) begin
                        s_nxt.stage[STG_BOOT_BIT] = s_r.stage[STG_BOOT_BIT];
                    end
                end
                REG_STANDBY_IDX: begin
                    if (sw_exec_from_ram) begin
                        s_nxt.stby = wbyte[STBY_BIT]; // [RL14]
                    end
                end
                REG_PROM_PORT_IDX: begin
                    if (prom_mode) s_nxt.pport = wbyte[1:0]; // [RL20]
                end
                REG_SYS_CFG3_IDX: s_nxt.sys = wbyte[1:0];
                default: s_nxt.sys = s_r.sys;
            endcase
        end
        // Busy reads flip bit six each time; a protected sequencer
        // does not toggle.
        if (cpu_rd && flash_sel) begin
            s_nxt.crd = flash_rdata;
            if (rd_toggle) begin
                s_nxt.tog = !s_r.tog; // [RL24] [RL3]
                s_nxt.crd[TOGGLE_BIT] = !s_r.tog;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_r <= '{stage: STAGING_RST, default: '0}; // [RL4]
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata       = s_r.rdata;
    assign cpu_rdata          = s_r.crd;
    assign standby_reset      = s_r.srst;
    assign flash_program      = cmd.prog;
    assign flash_sector_erase = cmd.sec_erase;
    assign flash_chip_erase   = cmd.chip_erase;
    assign flash_id_mode      = cmd.id_mode;
    assign flash_tgt_addr     = cmd.tgt_addr;
    assign flash_tgt_data     = cmd.tgt_data;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic commit_flash;
    assign commit_flash = wr_go && avs_address == REG_COMMIT_IDX
                       && wbyte == FLASH_KEY;

    chk_reset_disabled: assert property ( // [RL4]
        $fell(sys_rst) |-> !cmd_enabled
    ) else $error("sequencer enabled after reset");
    chk_enable_key: assert property ( // [RL1]
        commit_flash && s_r.stage[7:5] == MODE_ENABLE |=> cmd_enabled
    ) else $error("enable not applied on key");
    chk_disable_key: assert property ( // [RL2]
        commit_flash && s_r.stage[7:5] == MODE_DISABLE |=> !cmd_enabled
    ) else $error("protect not applied on key");
    chk_no_early: assert property ( // [RL25]
        !commit_flash |=> $stable(cmd_enabled)
    ) else $error("setting applied without key");
    chk_disabled_quiet: assert property ( // [RL3]
        !cmd_enabled |=> !(flash_program || flash_sector_erase
                           || flash_chip_erase)
    ) else $error("command ran while disabled");
    chk_standby_reset: assert property ( // [RL15]
        s_r.stby && flash_acc |=> standby_reset
    ) else $error("no standby reset on flash access");
    chk_irq_clear: assert property ( // [RL16]
        irq_vector_start && !vector_from_ram && !wr_go |=> !s_r.stby
    ) else $error("standby not cleared on interrupt");
    chk_standby_guard: assert property ( // [RL14]
        wr_go && avs_address == REG_STANDBY_IDX && !sw_exec_from_ram
        && !irq_vector_start |=> $stable(s_r.stby)
    ) else $error("standby written from flash code");
    chk_mcu_ports: assert property ( // [RL20]
        !prom_mode |-> sclk_in_en && other_in_en
    ) else $error("port gating active in MCU mode");
    chk_prom_boot: assert property ( // [RL13]
        prom_mode && in_boot_data |-> bootrom_sel && !flash_sel
    ) else $error("boot ROM not mapped in PROM mode");
    chk_toggle_bit: assert property ( // [RL24]
        rd_toggle ##[1:3] rd_toggle |=>
            cpu_rdata[TOGGLE_BIT] != $past(cpu_rdata[TOGGLE_BIT])
    ) else $error("bit six did not toggle");

    cov_enable: cover property (commit_flash ##1 cmd_enabled);
    cov_program: cover property (flash_program);
    cov_standby: cover property (standby_reset);
endmodule

//--- tb/fcmc_cpu_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// CPU core model: one-cycle data-space transfers on the bus.
// ----------------------------------------------------------------
module fcmc_cpu_model (
    input  wire logic        clk_sys,
    output logic      [15:0] cpu_addr,
    output logic             cpu_code_space,
    output logic             cpu_fetch,
    output logic             cpu_rd,
    output logic             cpu_wr,
    output logic      [7:0]  cpu_wdata
);
    // The bus starts idle; fetches are not modelled.
    initial begin
        cpu_addr = 16'h0000;
        cpu_code_space = 1'b0;
        cpu_fetch = 1'b0;
        cpu_rd = 1'b0;
        cpu_wr = 1'b0;
        cpu_wdata = 8'h00;
    end
    // Strobe one cycle, then invert the data so a stale byte never
    // looks like a fresh one.
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge clk_sys);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= w;
        cpu_rd <= !w;
        @(posedge clk_sys);
        cpu_wr <= 1'b0;
        cpu_rd <= 1'b0;
        cpu_wdata <= ~d;
    endtask
endmodule

//--- tb/fcmc_top_tb.sv
`timescale 1ns/1ns
module fcmc_top_tb;
    typedef struct packed {
        logic [11:0] a;
        logic [7:0]  d;
        logic [7:0]  e;
    } fcmc_row_t;
    logic        clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic        prom_mode, sw_exec_from_ram, irq_vector_start, flash_busy;
    logic        cpu_code_space, cpu_fetch, cpu_rd, cpu_wr, flash_sel;
    logic        bootrom_sel, ram_in_code, code_window_mapped, cmd_enabled;
    logic        vector_from_ram, flash_program, flash_sector_erase;
    logic        flash_chip_erase, flash_id_mode, standby_reset;
    logic        sclk_in_en, other_in_en;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, x;
    logic [7:0]  flash_rdata, cpu_rdata, cpu_wdata, flash_tgt_data;
    logic [15:0] cpu_addr, flash_tgt_addr;
    int          num_errors = 0, n_checks = 0;
    int          np = 0, ns = 0, nc = 0, nr = 0;
    fcmc_row_t   rows [8] = '{
        '{12'hFD0, 8'h4B, 8'h48}, '{12'hFD1, 8'hD5, 8'h08},
        '{12'hFD0, 8'hA0, 8'hA0}, '{12'hFD1, 8'h00, 8'h08},
        '{12'hFD1, 8'hD5, 8'h20}, '{12'hFD3, 8'h03, 8'h00},
        '{12'hFD2, 8'h01, 8'h00}, '{12'h010, 8'hFF, 8'h00}};
    fcmc_top fcmc_top_inst (.*);
    fcmc_cpu_model fcmc_cpu_model_inst (.*);
    // ------------------------------------------------------------
    // Clock and pulse counters, sampled away from the active edge.
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        if (flash_program === 1'b1) np++;
        if (flash_sector_erase === 1'b1) ns++;
        if (flash_chip_erase === 1'b1) nc++;
        if (standby_reset === 1'b1) nr++;
    end
    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Request held until waitrequest is seen low, released after.
    task automatic av(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        if (n >= 50) begin
            num_errors++;
            give_verdict;
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic cfg(input logic [11:0] a, input logic [7:0] d, k);
        av(1'b1, a, d);
        av(1'b1, a + 12'h1, k);
        @(negedge clk_sys);
    endtask
    task automatic cw(input logic [15:0] a, input logic [7:0] d);
        fcmc_cpu_model_inst.acc(1'b1, a, d);
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic cr(input logic [15:0] a);
        fcmc_cpu_model_inst.acc(1'b0, a, 8'h00);
        repeat (2) @(negedge clk_sys);
        rd = {24'h0, cpu_rdata};
    endtask
    task automatic seq(input logic [15:0] a, input logic [7:0] c, d);
        cw(16'hF555, 8'hAA);
        cw(16'hFAAA, 8'h55);
        cw(a, c);
        if (c == 8'h80) seq(a & 16'hF000 | 16'h0555, d, 8'h00);
    endtask
    task automatic rst;
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
    endtask
    task automatic irq;
        @(posedge clk_sys);
        irq_vector_start <= 1'b1;
        @(posedge clk_sys);
        irq_vector_start <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // Register rows first, then hand-written sequences.
    // ------------------------------------------------------------
    initial begin
        {avs_read, avs_write, prom_mode, sw_exec_from_ram} = 4'h0;
        {irq_vector_start, flash_busy, sys_rst} = 3'h1;
        {avs_address, avs_writedata, flash_rdata} = '0;
        flash_rdata = 8'h3C;
        rst;
        foreach (rows[i]) begin
            av(1'b1, rows[i].a, rows[i].d);
            av(1'b0, rows[i].a, 8'h00);
            chk("row", rd, {24'h0, rows[i].e});
        end
        $display("register rows done");
        cfg(12'hFD0, 8'hA8, 8'hD5);
        chk("en", cmd_enabled, 1);
        chk("map", code_window_mapped, 1);
        seq(16'hF555, 8'hA0, 8'h00);
        cw(16'hC000, 8'h12);
        x = {np[7:0], flash_tgt_addr, flash_tgt_data};
        chk("prog", x, 32'h01C00012);
        cw(16'hF555, 8'hAA);
        cw(16'hFAAA, 8'h55);
        cw(16'hF555, 8'h80);
        seq(16'hC400, 8'h30, 8'h00);
        chk("sec", {ns[15:0], flash_tgt_addr}, 32'h1C400);
        seq(16'h8555, 8'h80, 8'h10);
        chk("chip", nc, 1);
        $display("command sequences done");
        // Busy reads flip bit six only while commands are enabled.
        @(posedge clk_sys);
        flash_busy <= 1'b1;
        cr(16'h9000);
        x = rd;
        cr(16'h9000);
        chk("tog", rd[6], !x[6]);
        cfg(12'hFD0, 8'h48, 8'hD5);
        cr(16'h9000);
        chk("tog_off", rd, 32'h3C);
        seq(16'hF555, 8'hA0, 8'h00);
        cw(16'hC000, 8'h34);
        chk("prog_off", {cmd_enabled, np[7:0]}, 1);
        $display("toggle and protect done");
        @(posedge clk_sys);
        {flash_busy, sw_exec_from_ram} <= 2'h1;
        av(1'b1, 12'hFD2, 8'h01);
        cr(16'h9000);
        chk("stby", nr, 1);
        irq;
        cr(16'h9000);
        chk("irq", nr, 1);
        $display("standby done");
        // Second reset, now in serial PROM mode.
        @(posedge clk_sys);
        prom_mode <= 1'b1;
        rst;
        @(negedge clk_sys);
        x = {sclk_in_en, other_in_en, ram_in_code};
        chk("pins", x, 32'h1);
        av(1'b1, 12'hFD3, 8'h02);
        av(1'b0, 12'hFD0, 8'h00);
        chk("boot", rd, 32'h50);
        chk("sclk", {sclk_in_en, other_in_en}, 2'h2);
        $display("serial PROM mode done");
        give_verdict;
    end
endmodule
